// file: hdl/slpc_bank.sv
// Per-port learning, transmit pause bypass and transceiver reset bank.
// Assumes a same-clock register master and a same-clock lookup
// pipeline; all outputs are registered.
`timescale 1ns/1ns
`default_nettype none
`include "slpc_map.svh"

module slpc_bank
    import slpc_pkg::*;
#(
    parameter int QUIET_CYCLES = `SLPC_XQUIET_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    // Address lookup decisions
    input wire slpc_pkg::slpc_lookup_req_type lookupReq,
    output slpc_pkg::slpc_lookup_ans_type lookupAns,
    // Per-port effective controls
    output logic [8:0] txPauseBypass,
    output logic [8:0] hwLearnEnable,
    output logic [8:0] refreshEnable,
    output logic [8:0] unknownSaCopy,
    // Transceiver reset
    output logic [4:0] xcvrReset,
    output logic [4:0] xcvrQuiet
);
    import slpc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [8:0] MAP_MASK = `SLPC_PORT_MAP_MASK; // Live map bits

    logic [8:0] pauseMap_reg, pauseMap_next; // Tx pause bypass bits
    logic [8:0] learningOffBits_reg, learningOffBits_next; // Learning off
    logic [8:0] hostLearningBits_reg, hostLearningBits_next; // Host learning
    logic [4:0] xcvrCtrl_reg, xcvrCtrl_next; // Transceiver reset bits
    logic [15:0] rdata_reg, rdata_next; // Read answer

    logic [8:0] hwLearn_reg, hwLearn_next; // Hardware add allowed
    logic [8:0] refresh_reg, refresh_next; // Refresh allowed
    logic [8:0] cpuCopy_reg, cpuCopy_next; // Unknown source copy
    logic [8:0] pauseOut_reg, pauseOut_next; // Pause bypass drive
    slpc_lookup_ans_type ans_reg, ans_next; // Lookup answer

    logic [8:0] hostEffective; // Host learning after override
    logic [4:0] heldNow; // Transceivers in reset
    logic [4:0] quietNow; // Transceivers settling

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Bits 15:9 and 7:6 are not stored, so a careless write of the
    // reserved bits can never change behaviour.
    always_comb
    begin
        pauseMap_next = pauseMap_reg;
        learningOffBits_next = learningOffBits_reg;
        hostLearningBits_next = hostLearningBits_reg;
        xcvrCtrl_next = xcvrCtrl_reg;
        if (regWrite)
        begin
            case (regAddr)
                // Pause bypass map
                `SLPC_TX_PAUSE_BYPASS_MAP_OFS:
                    pauseMap_next = regWdata[8:0] & MAP_MASK;
                // Learning off mask
                `SLPC_LEARNING_OFF_MASK_OFS:
                    learningOffBits_next = regWdata[8:0] & MAP_MASK;
                // Host learning select
                `SLPC_HOST_LEARNING_SELECT_OFS:
                    hostLearningBits_next = regWdata[8:0] & MAP_MASK;
                // Transceiver reset bits
                `SLPC_TRANSCEIVER_RESET_CTRL_OFS:
                    xcvrCtrl_next = regWdata[4:0];
                // Unmapped or read-only: ignored
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Answer stands only in the cycle after each read cycle; reserved bits read zero.
    always_comb
    begin
        rdata_next = 16'h0000;
        if (regRead)
        begin
            case (regAddr)
                // Pause bypass map
                `SLPC_TX_PAUSE_BYPASS_MAP_OFS:
                    rdata_next = {7'h00, pauseMap_reg};
                // Learning off mask
                `SLPC_LEARNING_OFF_MASK_OFS:
                    rdata_next = {7'h00, learningOffBits_reg};
                // Host learning select
                `SLPC_HOST_LEARNING_SELECT_OFS:
                    rdata_next = {7'h00, hostLearningBits_reg};
                // Transceiver reset bits
                `SLPC_TRANSCEIVER_RESET_CTRL_OFS:
                    rdata_next = {11'h000, xcvrCtrl_reg};
                // Live sequencer status
                `SLPC_XCVR_SETTLE_STATUS_OFS:
                begin
                    rdata_next[`SLPC_STAT_HELD_LSB +: `SLPC_XCVR_N] = heldNow;
                    rdata_next[`SLPC_STAT_QUIET_LSB +: `SLPC_XCVR_N] = quietNow;
                end
                // Unmapped reads answer zero
                default:
                    rdata_next = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Per-port learning policy
    // ----------------------------------------------------------------
    // Learning off wins over host learning, so the host bit is masked
    // before it steers anything.
    assign hostEffective = hostLearningBits_reg & ~learningOffBits_reg;

    always_comb
    begin
        // Pause: set bit bypasses, clear bit keeps normal handling
        pauseOut_next = pauseMap_reg & MAP_MASK;
        // Hardware add only with learning on and host learning off
        hwLearn_next = ~learningOffBits_reg & ~hostEffective & MAP_MASK;
        // Refresh survives host learning, not learning off
        refresh_next = ~learningOffBits_reg & MAP_MASK;
        // Unknown source copy only under effective host learning
        cpuCopy_next = hostEffective & MAP_MASK;
    end

    // ----------------------------------------------------------------
    // Lookup decision
    // ----------------------------------------------------------------
    // One answer per request, one cycle later, using the maps as they
    // stand in the request cycle. Ports 6 and 7 carry no live bits and
    // so fall back to plain hardware behaviour.
    always_comb
    begin
        logic offBit;
        logic hostBit;
        offBit = 1'b0;
        hostBit = 1'b0;
        ans_next = '0;
        if (lookupReq.valid && lookupReq.port <= 4'(`SLPC_MGMT_PORT_BIT))
        begin
            offBit = learningOffBits_reg[lookupReq.port];
            hostBit = hostEffective[lookupReq.port];
        end
        ans_next.valid = lookupReq.valid;
        ans_next.port = lookupReq.port;
        if (lookupReq.valid)
        begin
            if (offBit)
            begin
                // Learning off: no add, no refresh, no copy
                ans_next.addEntry = 1'b0;
                ans_next.refreshEntry = 1'b0;
                ans_next.copyToCpu = 1'b0;
            end
            else if (hostBit)
            begin
                // Software decides adds; known entries still refresh
                ans_next.addEntry = 1'b0;
                ans_next.refreshEntry = lookupReq.saKnown;
                ans_next.copyToCpu = !lookupReq.saKnown;
            end
            else
            begin
                // Plain hardware learning and refresh
                ans_next.addEntry = !lookupReq.saKnown;
                ans_next.refreshEntry = lookupReq.saKnown;
                ans_next.copyToCpu = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pauseMap_reg <= `SLPC_TX_PAUSE_BYPASS_RST;
            learningOffBits_reg <= `SLPC_LEARNING_OFF_RST;
            hostLearningBits_reg <= `SLPC_HOST_LEARNING_RST;
            xcvrCtrl_reg <= `SLPC_XCVR_RESET_RST;
            rdata_reg <= 16'h0000;
            hwLearn_reg <= MAP_MASK;
            refresh_reg <= MAP_MASK;
            cpuCopy_reg <= 9'h000;
            pauseOut_reg <= 9'h000;
            ans_reg <= '0;
        end
        else
        begin
            pauseMap_reg <= pauseMap_next;
            learningOffBits_reg <= learningOffBits_next;
            hostLearningBits_reg <= hostLearningBits_next;
            xcvrCtrl_reg <= xcvrCtrl_next;
            rdata_reg <= rdata_next;
            hwLearn_reg <= hwLearn_next;
            refresh_reg <= refresh_next;
            cpuCopy_reg <= cpuCopy_next;
            pauseOut_reg <= pauseOut_next;
            ans_reg <= ans_next;
        end
    end

    // ----------------------------------------------------------------
    // Transceiver reset sequencers
    // ----------------------------------------------------------------
    // A request shorter than the least hold is stretched here rather
    // than trusted to software; after release the quiet flag tells
    // the port logic to keep the transceiver idle.
    generate
        for (genvar i = 0; i < `SLPC_XCVR_N; i++)
        begin : gXcvr
            slpc_xcvr_reset_timer #(
                .QUIET_CYCLES(QUIET_CYCLES)
            ) uTimer (
                .clk(clk),
                .rst_n(rst_n),
                .resetRequest(xcvrCtrl_reg[i]),
                .xcvrReset(heldNow[i]),
                .xcvrQuiet(quietNow[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign regRdata = rdata_reg;
    assign lookupAns = ans_reg;
    assign txPauseBypass = pauseOut_reg;
    assign hwLearnEnable = hwLearn_reg;
    assign refreshEnable = refresh_reg;
    assign unknownSaCopy = cpuCopy_reg;
    assign xcvrReset = heldNow;
    assign xcvrQuiet = quietNow;

endmodule

`default_nettype wire

// file: hdl/slpc_map.svh
// Register offsets, field positions, reset values and timing counts
// for the switch learning, pause and transceiver control bank.
// Assumes byte addressing on an 8-bit register address, 16-bit data.
`ifndef SLPC_MAP_SVH
`define SLPC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLPC_TX_PAUSE_BYPASS_MAP_OFS 8'h3a
`define SLPC_LEARNING_OFF_MASK_OFS 8'h3c
`define SLPC_HOST_LEARNING_SELECT_OFS 8'h3e
`define SLPC_XCVR_SETTLE_STATUS_OFS 8'h40
`define SLPC_TRANSCEIVER_RESET_CTRL_OFS 8'h48

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define SLPC_PORT_MAP_W 9
`define SLPC_PORT_MAP_MASK 9'h13f
`define SLPC_MGMT_PORT_BIT 8
`define SLPC_XCVR_N 5
`define SLPC_STAT_HELD_LSB 0
`define SLPC_STAT_QUIET_LSB 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLPC_TX_PAUSE_BYPASS_RST 9'h000
`define SLPC_LEARNING_OFF_RST 9'h000
`define SLPC_HOST_LEARNING_RST 9'h000
`define SLPC_XCVR_RESET_RST 5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLPC_CLK_PERIOD_NS 10
`define SLPC_XRST_MIN_NS 400
`define SLPC_XRST_MIN_CYC ((`SLPC_XRST_MIN_NS + `SLPC_CLK_PERIOD_NS - 1) / `SLPC_CLK_PERIOD_NS)
`define SLPC_XQUIET_US 100
`define SLPC_XQUIET_CYC ((`SLPC_XQUIET_US * 1000) / `SLPC_CLK_PERIOD_NS)
`define SLPC_CNT_W 16

`endif

// file: hdl/slpc_pkg.sv
// Types shared by the learning, pause and transceiver control bank.
// Widths used here are written out; none come from the map header.
`include "slpc_map.svh"

package slpc_pkg;

    // Address lookup request from the forwarding pipeline
    typedef struct packed {
        logic valid;
        logic [3:0] port;
        logic saKnown;
    } slpc_lookup_req_type;

    // Learning decision returned one cycle later
    typedef struct packed {
        logic valid;
        logic [3:0] port;
        logic addEntry;
        logic refreshEntry;
        logic copyToCpu;
    } slpc_lookup_ans_type;

    // Transceiver reset sequencing states
    typedef enum logic [1:0] {
        XRST_IDLE,
        XRST_HOLD,
        XRST_QUIET
    } slpc_xrst_state_type;

endpackage

// file: hdl/slpc_xcvr_reset_timer.sv
// One transceiver reset sequencer: stretches a short reset request to
// the least hold time and then flags the quiet interval after it.
// Assumes clk at 100 MHz and a request level from the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "slpc_map.svh"

module slpc_xcvr_reset_timer
#(
    parameter int QUIET_CYCLES = `SLPC_XQUIET_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the control register
    input wire logic resetRequest,
    // Sequenced outputs
    output logic xcvrReset,
    output logic xcvrQuiet
);
    import slpc_pkg::*;

    localparam logic [`SLPC_CNT_W-1:0] MIN_CNT = `SLPC_CNT_W'(`SLPC_XRST_MIN_CYC);
    localparam logic [`SLPC_CNT_W-1:0] QUIET_CNT = `SLPC_CNT_W'(QUIET_CYCLES);

    slpc_xrst_state_type state_reg, state_next; // Sequencer state
    logic [`SLPC_CNT_W-1:0] cnt_reg, cnt_next; // Cycles in this state
    logic rst_reg, rst_next; // Reset drive
    logic quiet_reg, quiet_next; // Quiet flag

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            XRST_IDLE:
            begin
                // Any set request starts a hold
                if (resetRequest)
                begin
                    state_next = XRST_HOLD;
                    cnt_next = `SLPC_CNT_W'(1);
                end
            end
            XRST_HOLD:
            begin
                // Saturate so a long request cannot wrap
                if (cnt_reg < MIN_CNT)
                    cnt_next = cnt_reg + `SLPC_CNT_W'(1);
                // Release only once the least time has passed
                if (!resetRequest && cnt_reg >= MIN_CNT)
                begin
                    state_next = XRST_QUIET;
                    cnt_next = `SLPC_CNT_W'(1);
                end
            end
            XRST_QUIET:
            begin
                if (resetRequest)
                begin
                    // Re-arm restarts the whole sequence
                    state_next = XRST_HOLD;
                    cnt_next = `SLPC_CNT_W'(1);
                end
                else if (cnt_reg >= QUIET_CNT)
                begin
                    state_next = XRST_IDLE;
                    cnt_next = '0;
                end
                else
                    cnt_next = cnt_reg + `SLPC_CNT_W'(1);
            end
            default:
            begin
                state_next = XRST_IDLE;
                cnt_next = '0;
            end
        endcase
        rst_next = (state_next == XRST_HOLD);
        quiet_next = (state_next == XRST_QUIET);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= XRST_IDLE;
            cnt_reg <= '0;
            rst_reg <= 1'b0;
            quiet_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rst_reg <= rst_next;
            quiet_reg <= quiet_next;
        end
    end

    assign xcvrReset = rst_reg;
    assign xcvrQuiet = quiet_reg;

endmodule

`default_nettype wire

// file: dv/slpc_bank_asserts.sv
// Concurrent checks on the learning, pause and transceiver reset bank.
// Assumes binding to slpc_bank; sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module slpc_bank_asserts
#(
    parameter int QUIET_CYCLES = 20
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    // Lookup
    input wire slpc_pkg::slpc_lookup_req_type lookupReq,
    input wire slpc_pkg::slpc_lookup_ans_type lookupAns,
    // Derived controls
    input wire logic [8:0] txPauseBypass,
    input wire logic [8:0] hwLearnEnable,
    input wire logic [8:0] refreshEnable,
    input wire logic [8:0] unknownSaCopy,
    input wire logic [4:0] xcvrReset,
    input wire logic [4:0] xcvrQuiet
);
    import slpc_pkg::*;

    // ----------------------------------------
    // Helper counters for port 0 sequencing
    // ----------------------------------------
    logic [15:0] holdCnt_reg; // Cycles reset held
    logic [15:0] holdCnt_next;
    logic [15:0] quietCnt_reg; // Cycles quiet shown
    logic [15:0] quietCnt_next;

    // Next counts, cleared whenever the level drops
    always_comb
    begin
        holdCnt_next = xcvrReset[0] ? holdCnt_reg + 16'h0001 : 16'h0000;
        quietCnt_next = xcvrQuiet[0] ? quietCnt_reg + 16'h0001 : 16'h0000;
    end

    // Registers only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            holdCnt_reg <= 16'h0000;
            quietCnt_reg <= 16'h0000;
        end
        else
        begin
            holdCnt_reg <= holdCnt_next;
            quietCnt_reg <= quietCnt_next;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pause_map_a:
        assert property (regWrite && regAddr == 8'h3a |-> ##2
            txPauseBypass == ($past(regWdata[8:0], 2) & 9'h13f))
        else $error("pause bypass map not applied");
    learn_off_a:
        assert property (regWrite && regAddr == 8'h3c |-> ##2
            ((hwLearnEnable | refreshEnable | unknownSaCopy) & $past(regWdata[8:0], 2) & 9'h13f) == 9'h000)
        else $error("disabled port still learns");
    learn_mix_a:
        assert property (hwLearnEnable == (refreshEnable & ~unknownSaCopy))
        else $error("learning controls inconsistent");
    reserved_off_a:
        assert property (((txPauseBypass | refreshEnable | unknownSaCopy) & 9'h0c0) == 9'h000)
        else $error("reserved port bits active");
    rd_idle_a:
        assert property (!$past(regRead) |-> regRdata == 16'h0000)
        else $error("read data outside its cycle");
    look_ans_a:
        assert property (lookupReq.valid |=> lookupAns.valid && lookupAns.port == $past(lookupReq.port))
        else $error("lookup answer missing");
    look_copy_a:
        assert property (lookupAns.valid && (lookupAns.copyToCpu || lookupAns.refreshEntry)
            |-> $past(lookupReq.saKnown) == lookupAns.refreshEntry)
        else $error("copy or refresh against source state");
    xrst_rise_a:
        assert property (regWrite && regAddr == 8'h48 && regWdata[0] |-> ##2 xcvrReset[0])
        else $error("transceiver reset not raised");
    xrst_hold_a:
        assert property ($fell(xcvrReset[0]) |-> holdCnt_reg >= 16'd40 && xcvrQuiet[0])
        else $error("transceiver reset too short");
    quiet_len_a:
        assert property ($fell(xcvrQuiet[0]) |-> quietCnt_reg == 16'(QUIET_CYCLES))
        else $error("quiet interval wrong length");

    // Main scenarios reached
    cover property ($fell(xcvrQuiet[0]));
    cover property (lookupAns.valid && lookupAns.copyToCpu);
    cover property ($past(regRead) && regRdata != 16'h0000);
endmodule

bind slpc_bank slpc_bank_asserts #(.QUIET_CYCLES(QUIET_CYCLES)) chk (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .lookupReq(lookupReq), .lookupAns(lookupAns),
    .txPauseBypass(txPauseBypass), .hwLearnEnable(hwLearnEnable),
    .refreshEnable(refreshEnable), .unknownSaCopy(unknownSaCopy),
    .xcvrReset(xcvrReset), .xcvrQuiet(xcvrQuiet));

`default_nettype wire

// file: dv/slpc_bank_tb_top.sv
// Self-checking bench for the learning, pause and transceiver bank.
// Assumes a short quiet count so the reset sequence finishes quickly.
`timescale 1ns/1ns
`default_nettype none

module slpc_bank_tb_top;
    import slpc_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk;
    logic rst_n;
    logic [7:0] regAddr;
    logic [15:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [15:0] regRdata;
    slpc_lookup_req_type lookupReq;
    slpc_lookup_ans_type lookupAns;
    logic [8:0] txPauseBypass;
    logic [8:0] hwLearnEnable;
    logic [8:0] refreshEnable;
    logic [8:0] unknownSaCopy;
    logic [4:0] xcvrReset;
    logic [4:0] xcvrQuiet;
    int badCount; // Mismatches seen
    int nTests; // Comparisons made
    logic [8:0] offMap; // Learning off bits written
    logic [8:0] hostMap; // Host learning bits written
    logic [7:0] regs [4] = '{8'h3a, 8'h3c, 8'h3e, 8'h48};
    logic [15:0] masks [4] = '{16'h013f, 16'h013f, 16'h013f, 16'h001f};

    // Short quiet keeps the run brief
    slpc_bank #(.QUIET_CYCLES(20)) uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .lookupReq(lookupReq), .lookupAns(lookupAns), .txPauseBypass(txPauseBypass),
        .hwLearnEnable(hwLearnEnable), .refreshEnable(refreshEnable),
        .unknownSaCopy(unknownSaCopy), .xcvrReset(xcvrReset), .xcvrQuiet(xcvrQuiet));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic completeRun();
        if (badCount == 0 && nTests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Wait until derived outputs follow a write
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // One lookup, answer judged from the maps the bench wrote
    task automatic look(input logic [3:0] p, input logic k);
        logic [2:0] d;
        if (offMap[p])
            d = 3'b000;
        else if (hostMap[p])
            d = {1'b0, k, !k};
        else
            d = {!k, k, 1'b0};
        @(posedge clk);
        lookupReq <= '{valid: 1'b1, port: p, saKnown: k};
        @(posedge clk);
        lookupReq.valid <= 1'b0;
        #1;
        check({8'h00, lookupAns}, {8'h00, 1'b1, p, d});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testReset();
        logic [15:0] v;
        check({7'h00, hwLearnEnable}, 16'h013f);
        check({7'h00, txPauseBypass}, 16'h0000);
        foreach (regs[i])
        begin
            rd(regs[i], v);
            check(v, 16'h0000);
        end
    endtask

    // All ones written, reserved bits must read back clear
    task automatic testRegs();
        logic [15:0] v;
        foreach (regs[i])
        begin
            wr(regs[i], 16'hffff);
            rd(regs[i], v);
            check(v, masks[i]);
            wr(regs[i], 16'h0000);
        end
        wr(8'h50, 16'hffff);
        rd(8'h50, v);
        check(v, 16'h0000);
    endtask

    task automatic testPause();
        wr(8'h3a, 16'h01e1);
        settle();
        check({7'h00, txPauseBypass}, 16'h0121);
        wr(8'h3a, 16'h0000);
        settle();
        check({7'h00, txPauseBypass}, 16'h0000);
    endtask

    // Port 0 off beats host, 1 2 8 host, rest plain; WAN left clear
    task automatic testLookup();
        offMap = 9'h001;
        hostMap = 9'h107;
        wr(8'h3c, {7'h00, offMap});
        wr(8'h3e, {7'h00, hostMap});
        settle();
        check({7'h00, unknownSaCopy}, 16'h0106);
        check({7'h00, refreshEnable}, 16'h013e);
        check({7'h00, hwLearnEnable}, 16'h0038);
        for (int p = 0; p < 9; p++)
        begin
            look(p[3:0], 1'b0);
            look(p[3:0], 1'b1);
        end
    endtask

    // Port 0 pulsed too briefly on purpose, port 4 held
    task automatic testXcvr();
        int hold;
        int quiet;
        logic [15:0] v;
        // Reset already stood one cycle before the second write returns
        hold = 1;
        quiet = 0;
        repeat (100) @(posedge clk);
        wr(8'h48, 16'h0011);
        wr(8'h48, 16'h0010);
        #1;
        while (xcvrReset[0] === 1'b1 && hold < 200)
        begin
            @(posedge clk);
            #1;
            hold++;
        end
        check(16'(hold >= 40 && hold < 200), 16'h0001);
        while (xcvrQuiet[0] === 1'b1 && quiet < 200)
        begin
            @(posedge clk);
            #1;
            quiet++;
        end
        check(16'(quiet), 16'd20);
        rd(8'h40, v);
        check(v, 16'h0010);
        wr(8'h48, 16'h0000);
        settle();
        check({11'h000, xcvrQuiet}, 16'h0010);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        lookupReq = '0;
        offMap = 9'h000;
        hostMap = 9'h000;
        badCount = 0;
        nTests = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        testReset();
        testRegs();
        testPause();
        testLookup();
        testXcvr();
        completeRun();
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        #100000;
        badCount++;
        completeRun();
    end
endmodule

`default_nettype wire
